// ---- verilog/rid_pkg.sv ----
`default_nettype none
package rid_pkg;
    // Opcode fields: top six bits of the 16-bit instruction word
    localparam logic [5:0] OPC_ROT_LEFT_PLAIN = 6'h11; // 0100 01
    localparam logic [5:0] OPC_ROT_RIGHT_CARRY = 6'h0c; // 0011 00
    localparam int         OPC_MSB    = 15;
    localparam int         OPC_LSB    = 10;
    localparam int         DEST_BIT   = 9;
    localparam int         ACCESS_BIT = 8;
    localparam int         FILE_MSB   = 7;
    // Access bank split and indexed literal offset limit
    localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
    localparam logic [7:0] INDEXED_LIMIT   = 8'h5f;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [1:0] PHASE_FIRST     = 2'h0;
    localparam logic [1:0] PHASE_LAST      = 2'h3;

    typedef enum logic [1:0] {
        RID_DECODE  = 2'b00,
        RID_READ    = 2'b01,
        RID_PROCESS = 2'b11,
        RID_WRITE   = 2'b10
    } rid_phase_type;
endpackage
`default_nettype wire

// ---- verilog/rid_rotate_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module rid_rotate_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] operand,
    input  wire logic             carry_in,
    input  wire logic             right_thru_carry,
    output logic      [WIDTH-1:0] result,
    output logic                  carry_out,
    output logic                  negative,
    output logic                  zero
);
    always_comb begin
        if (right_thru_carry) begin
            result    = {carry_in, operand[WIDTH-1:1]};     // RQ2
            carry_out = operand[0];                         // RQ2
        end else begin
            result    = {operand[WIDTH-2:0], operand[WIDTH-1]}; // RQ1
            carry_out = carry_in;                           // RQ1
        end
        negative = result[WIDTH-1];
        zero     = (result == '0);
    end
endmodule
`default_nettype wire

// ---- verilog/rid_datapath.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] Opcode 0100 01da rotates left, bit 7 into bit 0, carry untouched, N and Z updated.
// [RQ2] Opcode 0011 00da rotates right via carry, bit 0 to carry, carry to bit 7, C N Z updated.
// [RQ3] Destination bit clear writes the working register, set writes the file register back.
// [RQ4] Access bit clear selects the access bank, set joins bank_pointer to the file field.
// [RQ5] Access bit clear with extended set on treats file fields up to 95 as indexed offsets.
// [RQ6] Each rotate is one word taking one cycle of four phases: decode, read, compute, write.
module rid_datapath (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [15:0] instr_word,
    input  wire logic        extended_enable,
    input  wire logic [3:0]  bank_pointer,
    input  wire logic [7:0]  index_base,
    input  wire logic [7:0]  file_rdata,
    output logic      [11:0] file_addr,
    output logic             file_read,
    output logic             file_write,
    output logic      [7:0]  file_wdata,
    output logic      [7:0]  work_reg,
    output logic             carry_flag,
    output logic             negative_flag,
    output logic             zero_flag,
    output logic             rotate_active,
    output logic      [1:0]  phase,
    output logic             instr_done
);
    rid_pkg::rid_phase_type state;
    rid_pkg::rid_phase_type next_state;

    logic [5:0]  in_opcode;
    logic        in_access;
    logic [7:0]  in_field;
    logic        hit_left;
    logic        hit_right;
    logic        hit_rotate;
    logic        dest_file;
    logic        is_left;
    logic        is_right;
    logic        is_rotate;
    logic        write_slot;
    logic [7:0]  operand;
    logic [7:0]  rot_result;
    logic        rot_carry;
    logic        rot_neg;
    logic        rot_zero;
    logic [11:0] next_addr;

    // Fields of the word on offer; only acted on in the decode phase
    assign in_opcode  = instr_word[rid_pkg::OPC_MSB:rid_pkg::OPC_LSB];
    assign in_access  = instr_word[rid_pkg::ACCESS_BIT];
    assign in_field   = instr_word[rid_pkg::FILE_MSB:0];
    assign hit_left   = (in_opcode == rid_pkg::OPC_ROT_LEFT_PLAIN);  // RQ1
    assign hit_right  = (in_opcode == rid_pkg::OPC_ROT_RIGHT_CARRY); // RQ2
    assign hit_rotate = hit_left || hit_right;

    // Latched kind drives the rest of the cycle, never a stale live word
    assign is_rotate  = is_left || is_right;
    assign write_slot = (state == rid_pkg::RID_WRITE) && is_rotate;

    always_comb begin
        case (state)
            rid_pkg::RID_DECODE:  next_state = rid_pkg::RID_READ;
            rid_pkg::RID_READ:    next_state = rid_pkg::RID_PROCESS;
            rid_pkg::RID_PROCESS: next_state = rid_pkg::RID_WRITE;
            rid_pkg::RID_WRITE:   next_state = rid_pkg::RID_DECODE;
            default:              next_state = rid_pkg::RID_DECODE;
        endcase
    end

    // Four phases per instruction cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= rid_pkg::RID_DECODE;
            phase <= rid_pkg::PHASE_FIRST;
        end else begin
            state <= next_state; // RQ6
            case (next_state)
                rid_pkg::RID_DECODE:  phase <= 2'h0;
                rid_pkg::RID_READ:    phase <= 2'h1;
                rid_pkg::RID_PROCESS: phase <= 2'h2;
                default:              phase <= rid_pkg::PHASE_LAST;
            endcase
        end
    end

    // Decode: latch the opcode kind
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            is_left  <= 1'b0;
            is_right <= 1'b0;
        end else if (state == rid_pkg::RID_DECODE) begin
            is_left  <= hit_left;  // RQ1
            is_right <= hit_right; // RQ2
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dest_file <= 1'b0;
        end else if (state == rid_pkg::RID_DECODE) begin
            dest_file <= instr_word[rid_pkg::DEST_BIT]; // RQ3
        end
    end

    // Formed from the live word so the address is ready for the read phase
    always_comb begin
        if (in_access) begin
            next_addr = {bank_pointer, in_field}; // RQ4
        end else if (extended_enable && in_field <= rid_pkg::INDEXED_LIMIT) begin
            // Wraps within 8 bits; base pointer high part is outside this block
            next_addr = {4'h0, 8'(index_base + in_field)}; // RQ5
        end else if (in_field >= rid_pkg::ACCESS_SPLIT) begin
            next_addr = {rid_pkg::ACCESS_HIGH_BANK, in_field}; // RQ4
        end else begin
            next_addr = {4'h0, in_field}; // RQ4
        end
    end

    // Held through the write-back, which lands in the next phase 0
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            file_addr <= 12'h000;
        end else if (state == rid_pkg::RID_DECODE && hit_rotate) begin
            file_addr <= next_addr; // RQ4 RQ5
        end
    end

    // Strobe and a valid address share the read phase
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            file_read <= 1'b0;
        end else begin
            file_read <= (state == rid_pkg::RID_DECODE) && hit_rotate; // RQ6
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            operand <= rid_pkg::RESET_BYTE;
        end else if (state == rid_pkg::RID_READ) begin
            operand <= file_rdata; // RQ6
        end
    end

    // High from read to write; low again once the result lands
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rotate_active <= 1'b0;
        end else if (state == rid_pkg::RID_DECODE) begin
            rotate_active <= hit_rotate; // RQ6
        end else if (state == rid_pkg::RID_WRITE) begin
            rotate_active <= 1'b0;
        end
    end

    rid_rotate_unit #(
        .WIDTH (8)
    ) u_rot (
        .operand          (operand),
        .carry_in         (carry_flag),
        .right_thru_carry (is_right),
        .result           (rot_result),
        .carry_out        (rot_carry),
        .negative         (rot_neg),
        .zero             (rot_zero)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= write_slot; // RQ6
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            negative_flag <= 1'b0;
            zero_flag     <= 1'b0;
        end else if (write_slot) begin
            negative_flag <= rot_neg;  // RQ1 RQ2
            zero_flag     <= rot_zero; // RQ1 RQ2
        end
    end

    // Left rotate leaves carry alone
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            carry_flag <= 1'b0;
        end else if (write_slot && is_right) begin
            carry_flag <= rot_carry; // RQ2
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            work_reg <= rid_pkg::RESET_BYTE;
        end else if (write_slot && !dest_file) begin
            work_reg <= rot_result; // RQ3
        end
    end

    // Pulse lines up with the address still held from this cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            file_write <= 1'b0;
        end else begin
            file_write <= write_slot && dest_file; // RQ3
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            file_wdata <= rid_pkg::RESET_BYTE;
        end else if (write_slot && dest_file) begin
            file_wdata <= rot_result; // RQ3
        end
    end
endmodule
`default_nettype wire

// ---- test/rid_datapath_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rid_datapath_asserts (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic [1:0] phase,
    input wire logic       file_read,
    input wire logic       rotate_active,
    input wire logic       file_write,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] work_reg,
    input wire logic       carry_flag,
    input wire logic       negative_flag,
    input wire logic       zero_flag,
    input wire logic       instr_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_phase_step;
        1'b1 |=> phase == $past(phase) + 2'h1;
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase skipped");
    property p_read_slot;
        file_read |-> phase == 2'h1;
    endproperty
    a_read_slot: assert property (p_read_slot) else $error("read off slot");
    property p_write_slot;
        file_write |-> phase == 2'h0 && instr_done && $past(file_read, 3);
    endproperty
    a_write_slot: assert property (p_write_slot) else $error("write off slot");
    property p_done_pulse;
        instr_done |=> !instr_done [*3];
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too often");
    property p_carry_hold;
        $changed(carry_flag) |-> instr_done;
    endproperty
    a_carry_hold: assert property (p_carry_hold) else $error("stray carry");
    property p_work_hold;
        $changed(work_reg) |-> instr_done && !file_write;
    endproperty
    a_work_hold: assert property (p_work_hold) else $error("stray work write");
    property p_flags_write;
        file_write |-> negative_flag == file_wdata[7] && zero_flag == (file_wdata == 8'h00);
    endproperty
    a_flags_write: assert property (p_flags_write) else $error("bad flags");
    property p_flags_hold;
        $changed({negative_flag, zero_flag}) |-> instr_done;
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("stray flags");
    property p_active_span;
        file_read |-> rotate_active [*3] ##1 !rotate_active;
    endproperty
    a_active_span: assert property (p_active_span) else $error("active span wrong");
endmodule
bind rid_datapath rid_datapath_asserts u_asserts (.ref_clk, .rstn, .phase, .file_read,
    .rotate_active, .file_write, .file_wdata, .work_reg, .carry_flag, .negative_flag,
    .zero_flag, .instr_done);
`default_nettype wire

// ---- test/rid_datapath_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rid_datapath_tb;
    localparam logic [5:0] op_l = rid_pkg::OPC_ROT_LEFT_PLAIN;
    localparam logic [5:0] op_r = rid_pkg::OPC_ROT_RIGHT_CARRY;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic        extended_enable = 1'b0;
    logic [3:0]  bank_pointer = 4'h0;
    logic [7:0]  index_base = 8'h00;
    logic [7:0]  file_rdata = 8'h00;
    logic [11:0] file_addr;
    logic [7:0]  file_wdata, work_reg;
    logic [1:0]  phase;
    logic        file_read, file_write, carry_flag, negative_flag, zero_flag, instr_done;
    logic        rotate_active;
    logic        c = 1'b0;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    rid_datapath DUT (.ref_clk, .rstn, .instr_word, .extended_enable, .bank_pointer,
        .index_base, .file_rdata, .file_addr, .file_read, .file_write, .file_wdata,
        .work_reg, .carry_flag, .negative_flag, .zero_flag, .rotate_active, .phase,
        .instr_done);
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Bench tracks carry itself; expectations never read back from the design
    task automatic rot(input logic [5:0] op, input logic d, a, input logic [7:0] f, v);
        logic [7:0]  r;
        logic [11:0] ad;
        int          n;
        r = (op == op_l) ? {v[6:0], v[7]} : {c, v[7:1]};
        ad = a ? {bank_pointer, f} : (extended_enable && f <= 8'h5f) ? {4'h0, f + index_base}
            : {(f >= 8'h60) ? 4'hf : 4'h0, f};
        while (phase !== 2'h0) @(posedge ref_clk) #1;
        instr_word = {op, d, a, f};
        file_rdata = v;
        n = 0;
        do begin
            @(posedge ref_clk) #1;
            n++;
            if (phase === 2'h1) chk({file_read, rotate_active}, 2'b11);
            if (phase === 2'h3) chk(file_addr, ad);
        end while (instr_done !== 1'b1 && n < 8);
        chk({instr_done, rotate_active, file_read}, 3'b100);
        chk(file_write, d);
        chk(d ? file_wdata : work_reg, r);
        if (op == op_r) c = v[0];
        chk({carry_flag, negative_flag, zero_flag}, {c, r[7], r == 8'h00});
    endtask
    task automatic t_left();
        bank_pointer = 4'h5;
        rot(op_l, 1'b0, 1'b1, 8'h12, 8'hab);
        rot(op_l, 1'b1, 1'b1, 8'h34, 8'h80);
        rot(op_l, 1'b1, 1'b1, 8'hff, 8'h00);
    endtask
    task automatic t_right();
        rot(op_r, 1'b0, 1'b0, 8'h70, 8'h01);
        rot(op_l, 1'b1, 1'b0, 8'h70, 8'h80);
        rot(op_r, 1'b1, 1'b0, 8'h70, 8'h40);
    endtask
    task automatic t_addr();
        rot(op_l, 1'b0, 1'b0, 8'h5f, 8'h01);
        extended_enable = 1'b1;
        index_base = 8'hf0;
        rot(op_r, 1'b0, 1'b0, 8'h5f, 8'hff);
        rot(op_l, 1'b0, 1'b0, 8'h60, 8'h0f);
        rot(op_r, 1'b0, 1'b1, 8'h5f, 8'h02);
    endtask
    task automatic t_refuse(input logic [15:0] word);
        logic [7:0] w;
        logic [2:0] fl;
        w = work_reg;
        fl = {carry_flag, negative_flag, zero_flag};
        instr_word = word;
        repeat (8) begin
            @(posedge ref_clk) #1;
            chk({file_read, rotate_active, file_write, instr_done, work_reg}, {4'h0, w});
            chk({carry_flag, negative_flag, zero_flag}, fl);
        end
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 rstn = 1'b1;
        t_left();
        t_right();
        t_addr();
        t_refuse(16'h3755);
        t_refuse(16'h4155);
        complete_run();
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 1000) begin
            err_count++;
            complete_run();
        end
    end
endmodule
`default_nettype wire
